/* File: src/sldsp_pkg.sv */
// constants shared by the load detection and stop block
// assumes a 32-bit apb slave with byte addresses on an 8-bit offset
package sldsp_pkg;
  localparam int unsigned load_w = 10;
  localparam int unsigned offset_w = 7;
  // offset steps shift the reading by 16 counts per step
  localparam int unsigned offset_shift = 4;
  localparam int unsigned filter_len = 4;
  localparam logic [9:0] load_max = 10'h3ff;

  localparam logic [7:0] addr_config = 8'h00;
  localparam logic [7:0] addr_switch_mode = 8'h04;
  localparam logic [7:0] addr_vel_thresh = 8'h08;
  localparam logic [7:0] addr_load_status = 8'h0c;
  localparam logic [7:0] addr_latch_pos = 8'h10;
  localparam logic [7:0] addr_int_status = 8'h14;
  localparam logic [7:0] addr_int_mask = 8'h18;
  localparam logic [7:0] addr_control = 8'h1c;

  // config fields
  localparam int unsigned cfg_filter_bit = 7;
  // switch_mode_config fields
  localparam int unsigned sw_stop_left_bit = 0;
  localparam int unsigned sw_stop_right_bit = 1;
  localparam int unsigned sw_pol_left_bit = 2;
  localparam int unsigned sw_pol_right_bit = 3;
  localparam int unsigned sw_latch_left_bit = 4;
  localparam int unsigned sw_latch_right_bit = 5;
  localparam int unsigned sw_soft_stop_bit = 6;
  localparam int unsigned sw_stall_halt_bit = 7;
  // load status fields
  localparam int unsigned st_stall_bit = 16;
  localparam int unsigned st_hard_bit = 17;
  localparam int unsigned st_soft_bit = 18;
  // interrupt bits
  localparam int unsigned int_w = 4;
  localparam int unsigned int_update_bit = 0;
  localparam int unsigned int_stall_bit = 1;
  localparam int unsigned int_left_bit = 2;
  localparam int unsigned int_right_bit = 3;
  // control fields
  localparam int unsigned ctl_release_bit = 0;

  localparam logic [7:0] config_reset = 8'h00;
  localparam logic [7:0] switch_mode_reset = 8'h00;
  localparam logic [3:0] int_mask_reset = 4'h0;
endpackage

/* File: src/sldsp_sync.sv */
// two-flop synchroniser for one asynchronous pin
// assumes the pin is free of glitches shorter than a clock period
`timescale 1ns/1ns
module sldsp_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* File: src/sldsp_filter.sv */
// pass-through or four-sample averaging of raw full-step load samples
// assumes sample_valid is a one-cycle pulse per full step on pclk
`timescale 1ns/1ns
module sldsp_filter #(
  parameter int unsigned W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic filter_en,
  input wire logic sample_valid,
  input wire logic [W-1:0] sample,
  output logic out_valid,
  output logic [W-1:0] out
);
  logic [1:0] cnt_q;
  logic [W+1:0] acc_q;
  logic [W+1:0] sum;

  assign sum = acc_q + {2'b00, sample};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      acc_q <= '0;
      out_valid <= 1'b0;
      out <= '0;
    end else begin
      out_valid <= 1'b0;
      if (!filter_en) begin
        // restart the window so enabling always begins at a fresh set
        cnt_q <= 2'h0;
        acc_q <= '0;
        if (sample_valid) begin
          out_valid <= 1'b1;
          out <= sample;
        end
      end else if (sample_valid) begin
        if (cnt_q == 2'h3) begin
          out_valid <= 1'b1;
          out <= sum[W+1:2];
          cnt_q <= 2'h0;
          acc_q <= '0;
        end else begin
          cnt_q <= cnt_q + 2'h1;
          acc_q <= sum;
        end
      end
    end
  end
endmodule

/* File: src/sldsp_top.sv */
// load reading, stall detection and stop requests for one axis
// assumes raw load samples, position and velocity arrive on pclk from the
// driver; reference switch pins are asynchronous
// Summary of operation
// - active reference switch latches actual position
// - stall stop is a hard stop with no deceleration ramp
// - load reading reaches zero or near it at maximum load
// - signed offset shifts reading; positive means less sensitive
// - reading rises as load falls; zero is highest load
// - filter off: one reading per full step
// - filter on: one reading per four full steps
// - filter on: reading derived from four raw measurements
// - stall halt enable stops motor at once on stall
// - load reading is 10-bit unsigned
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module sldsp_top #(
  parameter int unsigned POS_W = 32,
  parameter int unsigned VEL_W = 23
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic raw_load_valid,
  input wire logic [9:0] raw_load,
  input wire logic [POS_W-1:0] actual_position,
  input wire logic [VEL_W-1:0] actual_velocity,
  input wire logic ref_left_pin,
  input wire logic ref_right_pin,
  output logic hard_stop,
  output logic soft_stop,
  output logic irq
);
  logic [7:0] config_q;
  logic [7:0] switch_mode_config_q;
  logic [VEL_W-1:0] lower_velocity_threshold_q;
  logic [9:0] load_reading_q;
  logic load_valid_q;
  logic stall_q;
  logic [POS_W-1:0] latch_pos_q;
  logic [3:0] int_status_q;
  logic [3:0] int_mask_q;
  logic hard_stop_q;
  logic soft_stop_q;
  logic left_q;
  logic right_q;
  logic [31:0] prdata_q;

  logic ref_left_s;
  logic ref_right_s;
  logic left_act;
  logic right_act;
  logic left_rise;
  logic right_rise;
  logic filt_valid;
  logic [9:0] filt_load;
  logic signed [11:0] shifted;
  logic [9:0] load_d;
  logic stall_evt;
  logic wr_access;
  logic rd_access;
  logic setup;
  logic mapped;
  logic [31:0] rd_mux;
  logic release_wr;
  logic [3:0] int_events;
  logic [6:0] load_threshold_offset;
  logic filter_en;
  logic stall_halt_enable;

  assign load_threshold_offset = config_q[6:0];
  assign filter_en = config_q[sldsp_pkg::cfg_filter_bit];
  assign stall_halt_enable =
    switch_mode_config_q[sldsp_pkg::sw_stall_halt_bit];

  // bus decode
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      sldsp_pkg::addr_config: rd_mux = {24'h00_0000, config_q};
      sldsp_pkg::addr_switch_mode:
        rd_mux = {24'h00_0000, switch_mode_config_q};
      sldsp_pkg::addr_vel_thresh:
        rd_mux = 32'(lower_velocity_threshold_q);
      sldsp_pkg::addr_load_status: begin
        rd_mux[9:0] = load_reading_q;
        rd_mux[sldsp_pkg::st_stall_bit] = stall_q;
        rd_mux[sldsp_pkg::st_hard_bit] = hard_stop_q;
        rd_mux[sldsp_pkg::st_soft_bit] = soft_stop_q;
      end
      sldsp_pkg::addr_latch_pos: rd_mux = 32'(latch_pos_q);
      sldsp_pkg::addr_int_status: rd_mux = {28'h000_0000, int_status_q};
      sldsp_pkg::addr_int_mask: rd_mux = {28'h000_0000, int_mask_q};
      sldsp_pkg::addr_control: rd_mux = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  // read data is captured during setup so it comes from a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= sldsp_pkg::config_reset;
      switch_mode_config_q <= sldsp_pkg::switch_mode_reset;
      lower_velocity_threshold_q <= '0;
      int_mask_q <= sldsp_pkg::int_mask_reset;
    end else if (wr_access) begin
      if (paddr == sldsp_pkg::addr_config) begin
        config_q <= pwdata[7:0];
      end
      if (paddr == sldsp_pkg::addr_switch_mode) begin
        switch_mode_config_q <= pwdata[7:0];
      end
      if (paddr == sldsp_pkg::addr_vel_thresh) begin
        lower_velocity_threshold_q <= pwdata[VEL_W-1:0];
      end
      if (paddr == sldsp_pkg::addr_int_mask) begin
        int_mask_q <= pwdata[3:0];
      end
    end
  end

  assign release_wr = wr_access && (paddr == sldsp_pkg::addr_control) &&
    pwdata[sldsp_pkg::ctl_release_bit];

  // reference switches
  sldsp_sync u_sync_left (
    .pclk(pclk),
    .presetn(presetn),
    .d(ref_left_pin),
    .q(ref_left_s)
  );

  sldsp_sync u_sync_right (
    .pclk(pclk),
    .presetn(presetn),
    .d(ref_right_pin),
    .q(ref_right_s)
  );

  assign left_act = ref_left_s ^
    switch_mode_config_q[sldsp_pkg::sw_pol_left_bit];
  assign right_act = ref_right_s ^
    switch_mode_config_q[sldsp_pkg::sw_pol_right_bit];
  assign left_rise = left_act && !left_q;
  assign right_rise = right_act && !right_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_q <= 1'b0;
      right_q <= 1'b0;
    end else begin
      left_q <= left_act;
      right_q <= right_act;
    end
  end

  // latch holds the position of the most recent enabled switch edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_pos_q <= '0;
    end else if ((left_rise &&
                  switch_mode_config_q[sldsp_pkg::sw_latch_left_bit]) ||
                 (right_rise &&
                  switch_mode_config_q[sldsp_pkg::sw_latch_right_bit])) begin
      latch_pos_q <= actual_position;
    end
  end

  // load reading path
  sldsp_filter #(
    .W(sldsp_pkg::load_w)
  ) u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .filter_en(filter_en),
    .sample_valid(raw_load_valid),
    .sample(raw_load),
    .out_valid(filt_valid),
    .out(filt_load)
  );

  // offset moves the reading up or down; clamp keeps it in 10 bits
  assign shifted = $signed({2'b00, filt_load}) +
    $signed({load_threshold_offset[6], load_threshold_offset, 4'h0});

  always_comb begin
    if (shifted < 12'sd0) begin
      load_d = 10'h000;
    end else if (shifted > 12'sd1023) begin
      load_d = sldsp_pkg::load_max;
    end else begin
      load_d = shifted[9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_reading_q <= 10'h000;
      load_valid_q <= 1'b0;
    end else begin
      load_valid_q <= filt_valid;
      if (filt_valid) begin
        load_reading_q <= load_d;
      end
    end
  end

  // stall qualification; low velocities give unreliable readings
  assign stall_evt = load_valid_q && (load_reading_q == 10'h000) &&
    (actual_velocity >= lower_velocity_threshold_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_q <= 1'b0;
    end else if (load_valid_q) begin
      stall_q <= stall_evt;
    end
  end

  // stop outputs; hard stop stays until software releases it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hard_stop_q <= 1'b0;
    end else if (stall_evt && stall_halt_enable) begin
      hard_stop_q <= 1'b1;
    end else if (!switch_mode_config_q[sldsp_pkg::sw_soft_stop_bit] &&
                 ((left_act &&
                   switch_mode_config_q[sldsp_pkg::sw_stop_left_bit]) ||
                  (right_act &&
                   switch_mode_config_q[sldsp_pkg::sw_stop_right_bit]))) begin
      hard_stop_q <= 1'b1;
    end else if (release_wr) begin
      hard_stop_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_stop_q <= 1'b0;
    end else begin
      soft_stop_q <= switch_mode_config_q[sldsp_pkg::sw_soft_stop_bit] &&
        ((left_act && switch_mode_config_q[sldsp_pkg::sw_stop_left_bit]) ||
         (right_act && switch_mode_config_q[sldsp_pkg::sw_stop_right_bit]));
    end
  end

  assign hard_stop = hard_stop_q;
  assign soft_stop = soft_stop_q;

  // interrupts: an event in the clearing cycle survives the read
  assign int_events = {right_rise, left_rise, stall_evt, load_valid_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_q <= 4'h0;
    end else if (rd_access && (paddr == sldsp_pkg::addr_int_status)) begin
      int_status_q <= int_events;
    end else begin
      int_status_q <= int_status_q | int_events;
    end
  end

  assign irq = |(int_status_q & int_mask_q);

  // checks
  property p_latch;
    @(posedge pclk) disable iff (!presetn)
      (left_rise && switch_mode_config_q[sldsp_pkg::sw_latch_left_bit])
      |=> (latch_pos_q == $past(actual_position));
  endproperty
  a_latch: assert property (p_latch)
    else $error("left switch edge did not latch position");

  property p_stall_hard;
    @(posedge pclk) disable iff (!presetn)
      (stall_evt && stall_halt_enable) |=> hard_stop_q;
  endproperty
  a_stall_hard: assert property (p_stall_hard)
    else $error("stall did not raise hard stop");

  property p_stall_hold;
    @(posedge pclk) disable iff (!presetn)
      (hard_stop_q && !release_wr) |=> hard_stop_q;
  endproperty
  a_stall_hold: assert property (p_stall_hold)
    else $error("hard stop dropped without release");

  property p_zero_floor;
    @(posedge pclk) disable iff (!presetn)
      (filt_valid && (shifted <= 12'sd0)) |=> (load_reading_q == 10'h000);
  endproperty
  a_zero_floor: assert property (p_zero_floor)
    else $error("reading not zero at full load");

  property p_offset;
    @(posedge pclk) disable iff (!presetn)
      (filt_valid && (load_threshold_offset == 7'h00))
      |=> (load_reading_q == $past(filt_load));
  endproperty
  a_offset: assert property (p_offset)
    else $error("zero offset changed the reading");

  property p_monotonic;
    @(posedge pclk) disable iff (!presetn)
      (filt_valid && (shifted > 12'sd0) && (shifted < 12'sd1023))
      |=> (load_reading_q == $past(shifted[9:0]));
  endproperty
  a_monotonic: assert property (p_monotonic)
    else $error("reading does not follow load");

  property p_unfiltered;
    @(posedge pclk) disable iff (!presetn)
      (raw_load_valid && !filter_en) |-> ##2 load_valid_q;
  endproperty
  a_unfiltered: assert property (p_unfiltered)
    else $error("unfiltered step gave no reading");

  property p_filtered_rate;
    @(posedge pclk) disable iff (!presetn)
      (filt_valid && filter_en && $stable(filter_en))
      |=> (!filt_valid)[*3];
  endproperty
  a_filtered_rate: assert property (p_filtered_rate)
    else $error("filtered readings came too fast");

  property p_stall_cond;
    @(posedge pclk) disable iff (!presetn)
      stall_evt |-> (load_reading_q == 10'h000) &&
        (actual_velocity >= lower_velocity_threshold_q) ##1 stall_q;
  endproperty
  a_stall_cond: assert property (p_stall_cond)
    else $error("stall flag not set on qualified zero reading");
endmodule

/* File: verif/sldsp_motor_model.sv */
// motor and reference switch model for one axis
// assumes the bench asks for full steps and sets load, speed and switches
`timescale 1ns/1ns
module sldsp_motor_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step_req,
  input wire logic halt,
  input wire logic [9:0] load_level,
  input wire logic [22:0] vel_level,
  input wire logic left_active,
  input wire logic right_active,
  output logic raw_load_valid,
  output logic [9:0] raw_load,
  output logic [31:0] actual_position,
  output logic [22:0] actual_velocity,
  output logic ref_left_pin,
  output logic ref_right_pin
);
  // ramp settings kept by the controlling side; the block never sees them
  localparam int unsigned start_velocity = 1;
  localparam int unsigned stop_velocity = 2;
  localparam int unsigned zero_velocity_wait_time = 0;

  assign ref_left_pin = left_active;
  assign ref_right_pin = right_active;
  // a hard stop halts at once, so speed drops with no ramp
  assign actual_velocity = halt ? 23'h000000 : vel_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_load_valid <= 1'b0;
      raw_load <= 10'h000;
      actual_position <= 32'h0000_0000;
    end else if (step_req && !halt) begin
      raw_load_valid <= 1'b1;
      raw_load <= load_level;
      actual_position <= actual_position + 32'h0000_0001;
    end else begin
      raw_load_valid <= 1'b0;
      // junk outside the pulse so a late capture shows up
      raw_load <= ~raw_load;
    end
  end
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the load detection and stop block
// assumes an apb slave that answers within 20 access cycles and the motor model at the far side
`timescale 1ns/1ns
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, actual_position, rd, exp_pos;
  logic raw_load_valid, ref_left_pin, ref_right_pin;
  logic [9:0] raw_load, load_level;
  logic [22:0] actual_velocity, vel_level;
  logic hard_stop, soft_stop, irq, step_req, left_active, right_active;
  logic err;
  int miscompares;
  int check_count;

  sldsp_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .raw_load_valid(raw_load_valid),
    .raw_load(raw_load), .actual_position(actual_position),
    .actual_velocity(actual_velocity), .ref_left_pin(ref_left_pin),
    .ref_right_pin(ref_right_pin), .hard_stop(hard_stop),
    .soft_stop(soft_stop), .irq(irq)
  );

  sldsp_motor_model motor (
    .pclk(pclk), .presetn(presetn), .step_req(step_req), .halt(hard_stop),
    .load_level(load_level), .vel_level(vel_level),
    .left_active(left_active), .right_active(right_active),
    .raw_load_valid(raw_load_valid), .raw_load(raw_load),
    .actual_position(actual_position), .actual_velocity(actual_velocity),
    .ref_left_pin(ref_left_pin), .ref_right_pin(ref_right_pin)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      complete_run();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // let the access edge settle so callers see its effects on the pins
      @(posedge pclk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask

  // one full step; reading and stop settle within four edges of the pulse
  task automatic step(input logic [9:0] v);
    @(posedge pclk);
    load_level <= v;
    step_req <= 1'b1;
    @(posedge pclk);
    step_req <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    step_req = 1'b0;
    load_level = 10'h000;
    vel_level = 23'h000000;
    left_active = 1'b0;
    right_active = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;

    rdchk("config", sldsp_pkg::addr_config, 32'h0000_0000);
    rdchk("switch mode", sldsp_pkg::addr_switch_mode, 32'h0000_0000);
    rdchk("int mask", sldsp_pkg::addr_int_mask, 32'h0000_0000);
    wr(sldsp_pkg::addr_load_status, 32'h0000_03ff);
    rdchk("load status", sldsp_pkg::addr_load_status, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test reset done");

    wr(sldsp_pkg::addr_vel_thresh, 32'h0000_0100);
    wr(sldsp_pkg::addr_int_mask, 32'h0000_0001);
    step(10'h1f4);
    rdchk("reading", sldsp_pkg::addr_load_status,
          32'h0000_01f4);
    chk("irq update", 32'h0000_0001, {31'h0, irq});
    rdchk("int status", sldsp_pkg::addr_int_status, 32'h0000_0001);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    step(10'h12c);
    rdchk("more load", sldsp_pkg::addr_load_status,
          32'h0000_012c);
    wr(sldsp_pkg::addr_int_mask, 32'h0000_0000);
    $display("test unfiltered done");

    wr(sldsp_pkg::addr_config, 32'h0000_0002);
    step(10'h12c);
    rdchk("offset +2", sldsp_pkg::addr_load_status,
          32'h0000_014c);
    wr(sldsp_pkg::addr_config, 32'h0000_007f);
    step(10'h12c);
    rdchk("offset -1", sldsp_pkg::addr_load_status,
          32'h0000_011c);
    wr(sldsp_pkg::addr_config, 32'h0000_003f);
    step(10'h3e8);
    rdchk("clamp top", sldsp_pkg::addr_load_status,
          32'h0000_03ff);
    wr(sldsp_pkg::addr_config, 32'h0000_007f);
    step(10'h00a);
    rdchk("clamp zero", sldsp_pkg::addr_load_status,
          32'h0000_0000);
    chk("slow no stop", 32'h0000_0000, {31'h0, hard_stop});
    $display("test offset done");

    wr(sldsp_pkg::addr_config, 32'h0000_0080);
    step(10'h064);
    step(10'h0c8);
    step(10'h12c);
    rdchk("held", sldsp_pkg::addr_load_status,
          32'h0000_0000);
    step(10'h191);
    rdchk("filtered", sldsp_pkg::addr_load_status,
          32'h0000_00fa);
    $display("test filter done");

    wr(sldsp_pkg::addr_config, 32'h0000_0000);
    wr(sldsp_pkg::addr_vel_thresh, 32'h0000_0064);
    vel_level <= 23'h0000c8;
    wr(sldsp_pkg::addr_int_status, 32'h0000_0000);
    rdchk("int flush", sldsp_pkg::addr_int_status, 32'h0000_0001);
    wr(sldsp_pkg::addr_switch_mode, 32'h0000_0080);
    step(10'h000);
    chk("stall halt", 32'h0000_0001, {31'h0, hard_stop});
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b0, sldsp_pkg::addr_load_status, 32'h0000_0000);
    chk("hard flag", 32'h0003_0000, rd & 32'h0003_03ff);
    wr(sldsp_pkg::addr_int_mask, 32'h0000_0002);
    chk("irq stall", 32'h0000_0001, {31'h0, irq});
    rdchk("stall event", sldsp_pkg::addr_int_status,
          32'h0000_0003);
    chk("irq gone", 32'h0000_0000, {31'h0, irq});
    wr(sldsp_pkg::addr_control, 32'h0000_0001);
    chk("released", 32'h0000_0000, {31'h0, hard_stop});
    vel_level <= 23'h000032;
    step(10'h000);
    chk("below speed", 32'h0000_0000, {31'h0, hard_stop});
    wr(sldsp_pkg::addr_switch_mode, 32'h0000_0000);
    vel_level <= 23'h0000c8;
    rdchk("no event", sldsp_pkg::addr_int_status,
          32'h0000_0001);
    step(10'h000);
    chk("halt off", 32'h0000_0000, {31'h0, hard_stop});
    rdchk("event only", sldsp_pkg::addr_int_status,
          32'h0000_0003);
    $display("test stall done");

    wr(sldsp_pkg::addr_switch_mode, 32'h0000_0051);
    exp_pos = actual_position;
    left_active <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("soft stop", 32'h0000_0001, {31'h0, soft_stop});
    chk("no hard", 32'h0000_0000, {31'h0, hard_stop});
    rdchk("latch", sldsp_pkg::addr_latch_pos, exp_pos);
    rdchk("left event", sldsp_pkg::addr_int_status, 32'h0000_0004);
    left_active <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("soft gone", 32'h0000_0000, {31'h0, soft_stop});
    wr(sldsp_pkg::addr_switch_mode, 32'h0000_0002);
    right_active <= 1'b1;
    repeat (6) @(posedge pclk);
    chk("switch hard", 32'h0000_0001, {31'h0, hard_stop});
    right_active <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(sldsp_pkg::addr_control, 32'h0000_0001);
    chk("cleared", 32'h0000_0000, {31'h0, hard_stop});
    // inverted right polarity with the pin low reads as an active switch
    step(10'h1f4);
    exp_pos = actual_position;
    wr(sldsp_pkg::addr_switch_mode, 32'h0000_0028);
    repeat (6) @(posedge pclk);
    rdchk("latch right", sldsp_pkg::addr_latch_pos,
          exp_pos);
    rdchk("right event", sldsp_pkg::addr_int_status, 32'h0000_0009);
    $display("test switch done");
    complete_run();
  end
endmodule
